// *** pcm_control.sv ***
// current-mode pwm control: oscillator, on-time latch, soft-start, blanking, axi4-lite registers
module pcm_control #(
  parameter int SS_STEP_CYC      = pcm_pkg::SS_STEP_CYCLES,
  parameter int SS_TOTAL_CYC     = pcm_pkg::SS_TOTAL_CYCLES,
  parameter int JITTER_PERIOD_CY = pcm_pkg::JITTER_PERIOD_CYC
) (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  // analog side
  input  wire logic                    supply_ok,
  input  wire pcm_pkg::pcm_compare_type compares,
  // power stage
  output logic                         gate_drive,
  output logic                         ramp_discharge_switch,
  // axi4-lite write address
  input  wire logic [31:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // axi4-lite read address
  input  wire logic [31:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);

  localparam int          JIT_SPAN   = 2 * pcm_pkg::JITTER_CYCLES;
  localparam int          JIT_STEP   = JITTER_PERIOD_CY / (2 * JIT_SPAN);
  localparam logic [7:0]  PERIOD_MIN = 8'(pcm_pkg::PERIOD_CYCLES - pcm_pkg::JITTER_CYCLES);
  localparam logic [3:0]  JIT_CENTER = 4'(pcm_pkg::JITTER_CYCLES);
  localparam logic [3:0]  JIT_TOP    = 4'(JIT_SPAN);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers: supply level for the soft-start counters, latch control and status; comparators for status only
  logic [3:0] async_in;
  logic [3:0] sync_a;
  logic [3:0] sync_b;

  assign async_in = {supply_ok, compares};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      always_ff @(posedge mclk)
      begin
        if (!resetn)
        begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end
        else
        begin
          sync_a[gi] <= async_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  logic supply_s;
  logic supply_q;
  logic supply_rise;

  assign supply_s    = sync_b[3];
  assign supply_rise = supply_s & ~supply_q;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      supply_q <= 1'b0;
    else
      supply_q <= supply_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register
  logic [31:0] ctrl;
  logic        restart_pulse;
  logic        run;
  logic        burst_mode;

  assign run        = ctrl[pcm_pkg::CTRL_RUN_BIT];
  assign burst_mode = ctrl[pcm_pkg::CTRL_BURST_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // soft-start: step counter and completion timer
  logic [4:0]  ss_step;
  logic [17:0] ss_step_cnt;
  logic [17:0] ss_total_cnt;
  logic        ss_done;
  logic        ss_restart;

  // a restart attempt is a fresh supply rise or a software restart
  assign ss_restart = supply_rise | restart_pulse;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      ss_step      <= 5'h00;
      ss_step_cnt  <= 18'h00000;
      ss_total_cnt <= 18'h00000;
      ss_done      <= 1'b0;
    end
    else if (!supply_s || ss_restart)
    begin
      ss_step      <= 5'h00;
      ss_step_cnt  <= 18'h00000;
      ss_total_cnt <= 18'h00000;
      ss_done      <= 1'b0;
    end
    else if (!ss_done)
    begin
      if (ss_total_cnt == 18'(SS_TOTAL_CYC - 1))
        ss_done <= 1'b1;
      ss_total_cnt <= ss_total_cnt + 18'h00001;
      if (ss_step_cnt == 18'(SS_STEP_CYC - 1))
      begin
        ss_step_cnt <= 18'h00000;
        if (ss_step != 5'(pcm_pkg::SS_STEPS - 1))
          ss_step <= ss_step + 5'h01;
      end
      else
        ss_step_cnt <= ss_step_cnt + 18'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // jitter: triangular sweep of the period offset
  logic [15:0] jit_cnt;
  logic [3:0]  jit_pos;
  logic        jit_up;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      jit_cnt <= 16'h0000;
      jit_pos <= JIT_CENTER;
      jit_up  <= 1'b1;
    end
    else if (!ss_done)
    begin
      // parked at nominal until normal operation begins
      jit_cnt <= 16'h0000;
      jit_pos <= JIT_CENTER;
      jit_up  <= 1'b1;
    end
    else if (jit_cnt == 16'(JIT_STEP - 1))
    begin
      jit_cnt <= 16'h0000;
      if (jit_up)
      begin
        jit_pos <= jit_pos + 4'h1;
        if (jit_pos == JIT_TOP - 4'h1)
          jit_up <= 1'b0;
      end
      else
      begin
        jit_pos <= jit_pos - 4'h1;
        if (jit_pos == 4'h1)
          jit_up <= 1'b1;
      end
    end
    else
      jit_cnt <= jit_cnt + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator
  logic [7:0]  period_now;
  logic [7:0]  cyc;
  logic [7:0]  max_on;
  logic        osc_on;
  logic [12:0] ss_limit;

  assign period_now = PERIOD_MIN + {4'h0, jit_pos};
  // longest on-window rounds down
  assign max_on     = 8'((10'(period_now) * 10'(pcm_pkg::DUTY_MAX_NUM))
                         >> pcm_pkg::DUTY_MAX_SHIFT);
  assign osc_on     = cyc < max_on;
  assign ss_limit   = 13'((13'(max_on) * 13'(ss_step)) >> 5);

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      cyc <= 8'h00;
    else if (cyc >= period_now - 8'h01)
      cyc <= 8'h00;
    else
      cyc <= cyc + 8'h01;
  end

  // discharge switch closed through the off phase
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      ramp_discharge_switch <= 1'b1;
    else
      ramp_discharge_switch <= ~(cyc + 8'h01 < max_on && cyc + 8'h01 < period_now);
  end

  ////////////////////////////////////////////////////////////////////////////
  // minimum off delay after the oscillator turn-off edge
  logic [1:0] off_cnt;
  logic       off_hold;

  assign off_hold = off_cnt != 2'h0;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      off_cnt <= 2'h0;
    else if (cyc == max_on)
      off_cnt <= 2'(pcm_pkg::OFF_DELAY_CYCLES);
    else if (off_hold)
      off_cnt <= off_cnt - 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // on-time latch, blanking and immediate clear
  logic       on_latch;
  logic [1:0] blank_cnt;
  logic       blank_active;
  logic [7:0] on_cnt;
  logic       ss_hit;
  logic       clear_now;
  logic       set_now;

  assign blank_active = blank_cnt != 2'h0;
  assign ss_hit       = ~ss_done & on_latch & ({5'h00, on_cnt} >= ss_limit);
  // raw comparator levels on purpose: a clock edge would add up to 100ns of overshoot
  assign clear_now    = ~blank_active
                        & (compares.feedback_compare
                           | compares.current_limit_compare
                           | (burst_mode & compares.burst_limit_compare));
  assign set_now      = (cyc == 8'h00) & ~off_hold & run & supply_s
                        & (ss_done | ss_limit != 13'h0000);

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      on_latch <= 1'b0;
    else if (!supply_s || !run)
      on_latch <= 1'b0;
    else if (on_latch && (clear_now || ss_hit || !osc_on))
      on_latch <= 1'b0;
    else if (set_now)
      on_latch <= 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      blank_cnt <= 2'h0;
      on_cnt    <= 8'h00;
    end
    else if (set_now && !on_latch)
    begin
      blank_cnt <= 2'(pcm_pkg::BLANK_CYCLES);
      on_cnt    <= 8'h01;
    end
    else
    begin
      if (blank_active)
        blank_cnt <= blank_cnt - 2'h1;
      if (on_latch)
        on_cnt <= on_cnt + 8'h01;
    end
  end

  // gate follows the latch but drops combinationally on a trip
  assign gate_drive = on_latch & ~clear_now & ~off_hold & supply_ok;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  function automatic logic [1:0] decode(input logic [31:0] addr);
    if (addr == pcm_pkg::CTRL_ADDR)
      decode = 2'h1;
    else if (addr == pcm_pkg::STATUS_ADDR)
      decode = 2'h2;
    else
      decode = 2'h0;
  endfunction

  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_got;
  logic        w_got;
  logic        wr_fire;

  assign wr_fire = aw_got & w_got & ~s_axi_bvalid;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      aw_got        <= 1'b0;
      s_axi_awready <= 1'b1;
      awaddr_q      <= 32'h0000_0000;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got        <= 1'b1;
      s_axi_awready <= 1'b0;
      awaddr_q      <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_got <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_awready <= 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      w_got        <= 1'b0;
      s_axi_wready <= 1'b1;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_got        <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_q      <= s_axi_wdata;
      wstrb_q      <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_got <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_wready <= 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pcm_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (decode(awaddr_q) == 2'h1) ? pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // restart bit is a one-shot, never stored
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      ctrl          <= pcm_pkg::CTRL_RESET;
      restart_pulse <= 1'b0;
    end
    else
    begin
      restart_pulse <= 1'b0;
      if (wr_fire && decode(awaddr_q) == 2'h1 && wstrb_q[0])
      begin
        ctrl          <= {30'h0, wdata_q[pcm_pkg::CTRL_BURST_BIT], wdata_q[pcm_pkg::CTRL_RUN_BIT]};
        restart_pulse <= wdata_q[pcm_pkg::CTRL_RESTART_BIT];
      end
    end
  end

  pcm_pkg::pcm_status_type status;

  always_comb
  begin
    status              = '0;
    status.supply_ok    = supply_s;
    status.ss_done      = ss_done;
    status.jitter_on    = ss_done;
    status.latch_on     = on_latch;
    status.ss_step      = ss_step;
    status.compares     = sync_b[2:0];
    status.period       = period_now;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pcm_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      case (decode(s_axi_araddr))
        2'h1:
        begin
          s_axi_rdata <= ctrl;
          s_axi_rresp <= pcm_pkg::RESP_OKAY;
        end
        2'h2:
        begin
          s_axi_rdata <= status;
          s_axi_rresp <= pcm_pkg::RESP_OKAY;
        end
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= pcm_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// *** pcm_pkg.sv ***
// constants and carrier types for the current-mode pwm control block
package pcm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timebase
  localparam int CLK_HZ            = 10_000_000;
  localparam int CLK_MHZ           = 10;

  // oscillator
  localparam int SWITCH_HZ         = 65_000;
  localparam int PERIOD_CYCLES     = CLK_HZ / SWITCH_HZ;
  localparam int JITTER_PCT        = 4;
  localparam int JITTER_CYCLES     = PERIOD_CYCLES * JITTER_PCT / 100;
  localparam int JITTER_PERIOD_US  = 4000;
  localparam int JITTER_PERIOD_CYC = JITTER_PERIOD_US * CLK_MHZ;
  localparam int DUTY_MAX_NUM      = 3;
  localparam int DUTY_MAX_SHIFT    = 2;

  // minimum off delay and leading edge blanking, least times round up
  localparam int OFF_DELAY_NS      = 156;
  localparam int OFF_DELAY_CYCLES  = (OFF_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_NS          = 220;
  localparam int BLANK_CYCLES      = (BLANK_NS * CLK_MHZ + 999) / 1000;

  // soft-start
  localparam int SS_STEPS          = 32;
  localparam int SS_STEP_US        = 600;
  localparam int SS_STEP_CYCLES    = SS_STEP_US * CLK_MHZ;
  localparam int SS_TOTAL_MS       = 20;
  localparam int SS_TOTAL_CYCLES   = SS_TOTAL_MS * 1000 * CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam logic [31:0] CTRL_ADDR    = 32'h0000_0000;
  localparam logic [31:0] STATUS_ADDR  = 32'h0000_0004;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

  // control fields
  localparam int CTRL_RUN_BIT      = 0;
  localparam int CTRL_BURST_BIT    = 1;
  localparam int CTRL_RESTART_BIT  = 2;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // analog comparator results, high when the comparator has tripped
  typedef struct packed {
    logic feedback_compare;
    logic current_limit_compare;
    logic burst_limit_compare;
  } pcm_compare_type;

  // status word, low bits first from the right
  typedef struct packed {
    logic [7:0]      reserved_hi;
    logic [7:0]      period;
    logic [3:0]      reserved_mid;
    pcm_compare_type compares;
    logic [4:0]      ss_step;
    logic            latch_on;
    logic            jitter_on;
    logic            ss_done;
    logic            supply_ok;
  } pcm_status_type;

endpackage

// *** pcm_control_sva.sv ***
// assertion checker for the pwm control block, bound to its ports
module pcm_control_sva #(
  parameter int SS_STEP_CYC      = pcm_pkg::SS_STEP_CYCLES,
  parameter int SS_TOTAL_CYC     = pcm_pkg::SS_TOTAL_CYCLES,
  parameter int JITTER_PERIOD_CY = pcm_pkg::JITTER_PERIOD_CYC
) (
  // clock and reset
  input wire logic                     mclk,
  input wire logic                     resetn,
  // analog side
  input wire logic                     supply_ok,
  input wire pcm_pkg::pcm_compare_type compares,
  // power stage
  input wire logic                     gate_drive,
  input wire logic                     ramp_discharge_switch
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int JMAX = pcm_pkg::PERIOD_CYCLES + pcm_pkg::JITTER_CYCLES;
  localparam int MAX_ON = JMAX * pcm_pkg::DUTY_MAX_NUM >> pcm_pkg::DUTY_MAX_SHIFT;
  localparam int MIN_PER = pcm_pkg::PERIOD_CYCLES - pcm_pkg::JITTER_CYCLES;
  logic [7:0] on_cnt;
  logic [7:0] gap_cnt;
  logic       gate_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////
  // consecutive on samples, and cycles since the last turn-on
  always_ff @(posedge mclk)
  begin
    on_cnt <= (resetn && gate_drive) ? on_cnt + 8'h01 : 8'h00;
  end

  // a supply drop saturates the gap so a fresh start is not judged
  always_ff @(posedge mclk)
  begin
    gate_q <= resetn && gate_drive;
    if (!resetn || !supply_ok)
      gap_cnt <= 8'hFF;
    else if (gate_drive && !gate_q)
      gap_cnt <= 8'h01;
    else if (gap_cnt != 8'hFF)
      gap_cnt <= gap_cnt + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence pulse_start_s;
    $rose(gate_drive);
  endsequence

  sequence late_trip_s(logic c);
    (on_cnt > 8'h04) && c;
  endsequence

  fb_clear_a: assert property (late_trip_s(compares.feedback_compare) |-> !gate_drive)
    else $error("gate stayed on past a feedback trip");
  climit_clear_a: assert property (late_trip_s(compares.current_limit_compare) |-> !gate_drive)
    else $error("gate stayed on past a current limit trip");
  blank_hold_a: assert property (pulse_start_s |-> (gate_drive || !supply_ok)[*2])
    else $error("gate cut inside the blanking interval");
  duty_limit_a: assert property (gate_drive |-> on_cnt < MAX_ON)
    else $error("on time above the duty limit");
  // the latch is registered, so it drops at the edge after the ramp switch closes
  off_delay_a: assert property ($rose(ramp_discharge_switch) |-> ##1 !gate_drive[*3])
    else $error("gate on inside the off delay");
  ramp_open_a: assert property (pulse_start_s |-> !ramp_discharge_switch && $past(ramp_discharge_switch))
    else $error("ramp switch not opened with the turn-on");
  uvlo_gate_a: assert property (!supply_ok |-> !gate_drive)
    else $error("gate on during undervoltage");
  period_gap_a: assert property (pulse_start_s |-> gap_cnt >= MIN_PER)
    else $error("two turn-ons within one period");
  ss_begin_a: assert property ($rose(supply_ok) |-> !gate_drive[*8])
    else $error("no zero duty step after supply rise");
endmodule

bind pcm_control pcm_control_sva #(
  .SS_STEP_CYC      (SS_STEP_CYC),
  .SS_TOTAL_CYC     (SS_TOTAL_CYC),
  .JITTER_PERIOD_CY (JITTER_PERIOD_CY)
) u_sva (
  .mclk                  (mclk),
  .resetn                (resetn),
  .supply_ok             (supply_ok),
  .compares              (compares),
  .gate_drive            (gate_drive),
  .ramp_discharge_switch (ramp_discharge_switch)
);

// *** pcm_sense_model.sv ***
// behavioural sense comparators, tripping after a set count of on cycles
module pcm_sense_model (
  // clock
  input  wire logic                mclk,
  // gate from the block
  input  wire logic                gate_drive,
  // trip points in on cycles, zero never trips
  input  wire logic [7:0]          fb_at,
  input  wire logic [7:0]          cl_at,
  input  wire logic [7:0]          bl_at,
  // comparator results
  output pcm_pkg::pcm_compare_type compares
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] on_cnt = 8'h00;

  // switch current collapses once the gate is off, so every trip clears
  always @(posedge mclk)
  begin
    on_cnt <= gate_drive ? on_cnt + 8'h01 : 8'h00;
    compares.feedback_compare <= gate_drive && fb_at != 8'h00 && on_cnt + 8'h01 >= fb_at;
    compares.current_limit_compare <= gate_drive && cl_at != 8'h00 && on_cnt + 8'h01 >= cl_at;
    compares.burst_limit_compare <= gate_drive && bl_at != 8'h00 && on_cnt + 8'h01 >= bl_at;
  end
endmodule

// *** current_mode_pwm_control_test.sv ***
// self-checking bench for the pwm control block with its sense comparators
module current_mode_pwm_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SS_TOTAL = 3400;
  localparam int PER = pcm_pkg::PERIOD_CYCLES;
  localparam int JIT = pcm_pkg::JITTER_CYCLES;
  localparam int ON_LO = (PER - JIT) * pcm_pkg::DUTY_MAX_NUM >> pcm_pkg::DUTY_MAX_SHIFT;
  localparam int ON_HI = (PER + JIT) * pcm_pkg::DUTY_MAX_NUM >> pcm_pkg::DUTY_MAX_SHIFT;
  localparam logic [31:0] CTRL = pcm_pkg::CTRL_ADDR;
  localparam logic [31:0] STAT = pcm_pkg::STATUS_ADDR;
  localparam logic [1:0] OK = pcm_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = pcm_pkg::RESP_SLVERR;
  typedef struct packed {
    logic [7:0] fb;
    logic [7:0] cl;
    logic [7:0] bl;
    logic       burst;
    logic [7:0] lo;
    logic [7:0] hi;
  } pcm_row_type;
  pcm_row_type              rows [9];
  logic                     mclk = 1'b0;
  logic                     resetn = 1'b0;
  logic                     supply_ok = 1'b0;
  logic [7:0]               fb_at = 8'h00;
  logic [7:0]               cl_at = 8'h00;
  logic [7:0]               bl_at = 8'h00;
  logic [31:0]              awaddr = 32'h0;
  logic [31:0]              wdata = 32'h0;
  logic [31:0]              araddr = 32'h0;
  logic [3:0]               wstrb = 4'hF;
  logic                     awvalid = 1'b0;
  logic                     wvalid = 1'b0;
  logic                     bready = 1'b0;
  logic                     arvalid = 1'b0;
  logic                     rready = 1'b0;
  logic                     awready;
  logic                     wready;
  logic                     bvalid;
  logic                     arready;
  logic                     rvalid;
  logic [1:0]               bresp;
  logic [1:0]               rresp;
  logic [31:0]              rdata;
  logic                     gate_drive;
  logic                     ramp;
  logic                     gate_q = 1'b0;
  pcm_pkg::pcm_compare_type compares;
  int                       fails = 0;
  int                       n_compared = 0;
  int                       cyc_now = 0;
  int                       hi_cnt = 0;
  int                       last_w = 0;
  int                       n_pulse = 0;
  int                       per_cnt = 0;
  int                       last_per = 0;

  pcm_control #(
    .SS_STEP_CYC      (100),
    .SS_TOTAL_CYC     (SS_TOTAL),
    .JITTER_PERIOD_CY (2400)
  ) dut (
    .mclk                  (mclk),
    .resetn                (resetn),
    .supply_ok             (supply_ok),
    .compares              (compares),
    .gate_drive            (gate_drive),
    .ramp_discharge_switch (ramp),
    .s_axi_awaddr          (awaddr),
    .s_axi_awvalid         (awvalid),
    .s_axi_awready         (awready),
    .s_axi_wdata           (wdata),
    .s_axi_wstrb           (wstrb),
    .s_axi_wvalid          (wvalid),
    .s_axi_wready          (wready),
    .s_axi_bresp           (bresp),
    .s_axi_bvalid          (bvalid),
    .s_axi_bready          (bready),
    .s_axi_araddr          (araddr),
    .s_axi_arvalid         (arvalid),
    .s_axi_arready         (arready),
    .s_axi_rdata           (rdata),
    .s_axi_rresp           (rresp),
    .s_axi_rvalid          (rvalid),
    .s_axi_rready          (rready)
  );

  pcm_sense_model u_sense (
    .mclk       (mclk),
    .gate_drive (gate_drive),
    .fb_at      (fb_at),
    .cl_at      (cl_at),
    .bl_at      (bl_at),
    .compares   (compares)
  );

  initial
  begin
    forever #50 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulse width and turn-on spacing, counted in sampled clock edges
  always @(posedge mclk)
  begin
    cyc_now <= cyc_now + 1;
    gate_q <= gate_drive;
    if (gate_drive)
      hi_cnt <= hi_cnt + 1;
    if (!gate_drive && hi_cnt != 0)
    begin
      last_w <= hi_cnt;
      hi_cnt <= 0;
      n_pulse <= n_pulse + 1;
    end
    per_cnt <= (gate_drive && !gate_q) ? 1 : per_cnt + 1;
    if (gate_drive && !gate_q)
      last_per <= per_cnt;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic give_up();
    fails++;
    $display("[ERR] %0t wait ran out", $time);
    conclude();
  endtask

  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 50; k++)
    begin
      @(posedge mclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        check(bresp, er);
        return;
      end
    end
    give_up();
  endtask

  task automatic axr(input logic [31:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 50; k++)
    begin
      @(posedge mclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        d = rdata;
        check(rresp, er);
        return;
      end
    end
    give_up();
  endtask

  task automatic pulses(input int n);
    int goal;
    goal = n_pulse + n;
    for (int k = 0; k < 400 * n && n_pulse < goal; k++)
      @(posedge mclk);
    if (n_pulse < goal)
      give_up();
  endtask

  task automatic run_to(input int t);
    for (int k = 0; k < 20000 && cyc_now < t; k++)
      @(posedge mclk);
    if (cyc_now < t)
      give_up();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] d;
    int          t0;
    int          w_prev;
    int          pmin;
    int          pmax;
    rows = '{'{8'h06, 8'h00, 8'h00, 1'b0, 8'h06, 8'h06}, '{8'h00, 8'h09, 8'h00, 1'b0, 8'h09, 8'h09},
             '{8'h0C, 8'h08, 8'h00, 1'b0, 8'h08, 8'h08}, '{8'h00, 8'h00, 8'h05, 1'b0, 8'(ON_LO), 8'(ON_HI)},
             '{8'h00, 8'h00, 8'h05, 1'b1, 8'h05, 8'h05}, '{8'h02, 8'h00, 8'h00, 1'b0, 8'h03, 8'h04},
             '{8'h00, 8'h01, 8'h00, 1'b0, 8'h03, 8'h04}, '{8'h00, 8'h00, 8'h02, 1'b1, 8'h03, 8'h04},
             '{8'h00, 8'h00, 8'h00, 1'b0, 8'(ON_LO), 8'(ON_HI)}};
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    check({gate_drive, ramp}, 2'b01);
    axr(CTRL, d, OK);
    check(d, pcm_pkg::CTRL_RESET);
    axr(32'h8, d, ERR);
    check(d, 32'h0);
    axw(STAT, 32'h1, ERR);
    axw(32'h8, 32'h1, ERR);
    axw(CTRL, 32'h1, OK);
    // low byte strobe off leaves the register alone
    wstrb <= 4'hE;
    axw(CTRL, 32'h3, OK);
    wstrb <= 4'hF;
    axr(CTRL, d, OK);
    check(d, 32'h1);
    // soft-start from supply rise: widths only grow, period held at nominal
    supply_ok <= 1'b1;
    t0 = cyc_now;
    w_prev = 0;
    for (int k = 0; k < 18; k++)
    begin
      pulses(1);
      check(last_w >= w_prev, 1'b1);
      if (k == 0)
        check(last_w <= 10, 1'b1);
      else
        check(last_per, PER);
      w_prev = last_w;
    end
    run_to(t0 + SS_TOTAL - 20);
    axr(STAT, d, OK);
    check(d[2:0], 3'b001);
    run_to(t0 + SS_TOTAL + 20);
    axr(STAT, d, OK);
    check(d[2:0], 3'b111);
    pmin = 999;
    pmax = 0;
    for (int k = 0; k < 40; k++)
    begin
      pulses(1);
      check(last_per >= PER - JIT && last_per <= PER + JIT, 1'b1);
      pmin = (last_per < pmin) ? last_per : pmin;
      pmax = (last_per > pmax) ? last_per : pmax;
    end
    check(pmin < PER && pmax > PER, 1'b1);
    foreach (rows[i])
    begin
      fb_at <= rows[i].fb;
      cl_at <= rows[i].cl;
      bl_at <= rows[i].bl;
      axw(CTRL, {30'h0, rows[i].burst, 1'b1}, OK);
      pulses(2);
      check(last_w >= rows[i].lo && last_w <= rows[i].hi, 1'b1);
    end
    // restart bit is one-shot and reruns the duty ramp
    axw(CTRL, 32'h5, OK);
    axr(CTRL, d, OK);
    check(d, 32'h1);
    axr(STAT, d, OK);
    check(d[1], 1'b0);
    pulses(2);
    check(last_w < ON_LO, 1'b1);
    for (int k = 0; k < 400 && !gate_drive; k++)
      @(posedge mclk);
    if (!gate_drive)
      give_up();
    supply_ok <= 1'b0;
    @(negedge mclk);
    check(gate_drive, 1'b0);
    repeat (5) @(posedge mclk);
    supply_ok <= 1'b1;
    repeat (3) @(posedge mclk);
    axr(STAT, d, OK);
    check(d[8:1], 8'h00);
    conclude();
  end
endmodule
